// File: lcsr_pkg.sv
// Constants shared by the line interface control and status register bank
package lcsr_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 8;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_INFO = 8'h11;
  localparam logic [7:0] IDX_STAT = 8'h14;
  localparam logic [7:0] IDX_MASK = 8'h15;
  localparam logic [7:0] IDX_JACK = 8'h31;
  localparam logic [7:0] IDX_MON_CMI = 8'h32;
  localparam logic [7:0] IDX_TERM_PS = 8'h33;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int B_GAIN_LO = 3;
  localparam int B_GAIN_HI = 4;
  localparam int B_CMI_INV = 6;
  localparam int B_CMI_EN  = 7;
  localparam int B_RT_LO   = 0;
  localparam int B_RT_HI   = 2;
  localparam int B_TT_LO   = 3;
  localparam int B_TT_HI   = 5;
  localparam int B_MPS_LO  = 6;
  localparam int B_MPS_HI  = 7;
  localparam int B_JA1     = 3;
  localparam int B_JA2     = 7;
  localparam int B_OC      = 1;
  localparam int B_CL      = 2;
  localparam int B_JA      = 4;
  localparam int B_LVL_HI  = 3;

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic [23:0] RD_PAD      = 24'h00_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// File: lcsr_regs.sv
// Line interface control and status registers behind an AXI4-Lite slave
//
// Contract
// - Monitor gain code selects 0/20/26/32 dB
// - Invert bit flips CMI polarity both pins
// - Enable bit switches line into CMI coding
// - Receive termination code: 75/100/120/110 or off
// - Transmit termination, same code as receive
// - Receive level reported live, 2.5 dB steps
// - Open circuit flag follows transmit detector
// - Open circuit flag meaningless in 6312 kHz
// - Current limit flag follows limiter activation
// - No current limit flag in CMI/64k/6312
// - Trip flag set near jitter FIFO limit
// - Trip flag latched, cleared by status read
// - Trip event only in T1 or E1
// - Masked-in level flags interrupt on both edges
// - Trip mask bit gates trip interrupt
// - Clock select bits enable conversion PLLs
`timescale 1ns/1ps

module lcsr_regs (
  // Clock, reset, enable
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  // AXI4-Lite write address and data
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [lcsr_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [lcsr_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [lcsr_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [lcsr_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // Operating mode from the core, same clock
  input  wire logic                         mode_t1e1,
  input  wire logic                         tx_mode_64k,
  input  wire logic                         tx_mode_6312,
  // Analogue detectors, asynchronous
  input  wire logic                         tx_open_det,
  input  wire logic                         tx_climit_det,
  input  wire logic                         ja_near_limit,
  input  wire logic [3:0]                   rx_level_in,
  // Line interface controls
  output logic [1:0]                        monitor_gain,
  output logic                              cmi_polarity_invert,
  output logic                              cmi_coding_enable,
  output logic [2:0]                        rx_term_sel,
  output logic [2:0]                        tx_term_sel,
  output logic [1:0]                        mclk_prescale,
  output logic                              ja_clk_select_first,
  output logic                              ja_clk_select_second,
  // Interrupt
  output logic                              irq_n
);
  import lcsr_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] gain;
    logic       cmi_inv;
    logic       cmi_en;
    logic [7:0] term_ps;
    logic       ja_first;
    logic       ja_second;
    logic       mask_oc;
    logic       mask_cl;
    logic       mask_ja;
    logic       trip;
    logic       pend_oc;
    logic       pend_cl;
    logic       oc_s1;
    logic       oc_s2;
    logic       oc_q;
    logic       cl_s1;
    logic       cl_s2;
    logic       cl_q;
    logic       ja_s1;
    logic       ja_s2;
    logic [3:0] lv_s1;
    logic [3:0] lv_s2;
    logic       aw_got;
    logic [7:0] aw_idx;
    logic       w_got;
    logic [7:0] wd;
    logic       wstb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] rd_idx;
  } lcsr_state_t;

  lcsr_state_t st_r;
  lcsr_state_t st_nxt;

  // Word index from byte address; low two bits ignored
  function automatic logic [IDX_W-1:0] idx_of(
    input logic [ADDR_W-1:0] a);
    idx_of = a[IDX_W+1:2];
  endfunction

  function automatic logic mapped(input logic [IDX_W-1:0] i);
    mapped = (i == IDX_INFO) || (i == IDX_STAT) || (i == IDX_MASK) ||
             (i == IDX_JACK) || (i == IDX_MON_CMI) || (i == IDX_TERM_PS);
  endfunction

  // ****************************************************************
  // Derived status
  // ****************************************************************
  logic       oc_now;
  logic       cl_now;
  logic       rd_take;
  logic       stat_rd;
  logic [7:0] rd_word;

  // Detectors are not trusted in modes where they do not run
  assign oc_now  = st_r.oc_s2 & ~tx_mode_6312;
  assign cl_now  = st_r.cl_s2 &
                   ~(st_r.cmi_en | tx_mode_64k | tx_mode_6312);
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign stat_rd = rd_take & (idx_of(s_axi_araddr) == IDX_STAT);

  // Read multiplexer; unused bits read zero
  always_comb begin
    rd_word = REG_RST;
    case (idx_of(s_axi_araddr))
      IDX_INFO: rd_word[B_LVL_HI:0] = st_r.lv_s2;
      IDX_STAT: begin
        rd_word[B_OC] = oc_now;
        rd_word[B_CL] = cl_now;
        rd_word[B_JA] = st_r.trip;
      end
      IDX_MASK: begin
        rd_word[B_OC] = st_r.mask_oc;
        rd_word[B_CL] = st_r.mask_cl;
        rd_word[B_JA] = st_r.mask_ja;
      end
      IDX_JACK: begin
        rd_word[B_JA1] = st_r.ja_first;
        rd_word[B_JA2] = st_r.ja_second;
      end
      IDX_MON_CMI: begin
        rd_word[B_GAIN_HI:B_GAIN_LO] = st_r.gain;
        rd_word[B_CMI_INV]           = st_r.cmi_inv;
        rd_word[B_CMI_EN]            = st_r.cmi_en;
      end
      IDX_TERM_PS: rd_word = st_r.term_ps;
      default:  rd_word = REG_RST;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Two flops on every analogue input
      st_nxt.oc_s1 = tx_open_det;
      st_nxt.oc_s2 = st_r.oc_s1;
      st_nxt.cl_s1 = tx_climit_det;
      st_nxt.cl_s2 = st_r.cl_s1;
      st_nxt.ja_s1 = ja_near_limit;
      st_nxt.ja_s2 = st_r.ja_s1;
      st_nxt.lv_s1 = rx_level_in;
      st_nxt.lv_s2 = st_r.lv_s1;
      st_nxt.oc_q  = oc_now;
      st_nxt.cl_q  = cl_now;

      // Status read clears pending events first
      if (stat_rd) begin
        st_nxt.trip    = 1'b0;
        st_nxt.pend_oc = 1'b0;
        st_nxt.pend_cl = 1'b0;
      end
      // New events win over a clear in the same cycle
      if (oc_now != st_r.oc_q)
        st_nxt.pend_oc = 1'b1;
      if (cl_now != st_r.cl_q)
        st_nxt.pend_cl = 1'b1;
      if (st_r.ja_s2 && mode_t1e1)
        st_nxt.trip = 1'b1;

      // Write address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
        st_nxt.aw_got = 1'b1;
        st_nxt.aw_idx = idx_of(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        st_nxt.w_got = 1'b1;
        st_nxt.wd    = s_axi_wdata[7:0];
        st_nxt.wstb  = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready)
        st_nxt.bvalid = 1'b0;
      // Commit once both halves are held; unused bits are dropped
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got  = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp  = mapped(st_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
        if (st_r.wstb) begin
          case (st_r.aw_idx)
            IDX_MASK: begin
              st_nxt.mask_oc = st_r.wd[B_OC];
              st_nxt.mask_cl = st_r.wd[B_CL];
              st_nxt.mask_ja = st_r.wd[B_JA];
            end
            IDX_JACK: begin
              st_nxt.ja_first  = st_r.wd[B_JA1];
              st_nxt.ja_second = st_r.wd[B_JA2];
            end
            IDX_MON_CMI: begin
              st_nxt.gain    = st_r.wd[B_GAIN_HI:B_GAIN_LO];
              st_nxt.cmi_inv = st_r.wd[B_CMI_INV];
              st_nxt.cmi_en  = st_r.wd[B_CMI_EN];
            end
            IDX_TERM_PS: st_nxt.term_ps = st_r.wd;
            default:     st_nxt.term_ps = st_r.term_ps;
          endcase
        end
      end

      // Read answered one cycle after the address is taken
      if (s_axi_rvalid && s_axi_rready)
        st_nxt.rvalid = 1'b0;
      if (rd_take) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata  = rd_word;
        st_nxt.rd_idx = idx_of(s_axi_araddr);
        st_nxt.rresp  = mapped(idx_of(s_axi_araddr)) ?
                        RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Synchronous reset, all fields to zero
  always_ff @(posedge aclk) begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ready only while a slot is free; ce low stalls the bus too
  assign s_axi_awready = ce & ~st_r.aw_got & ~st_r.bvalid;
  assign s_axi_wready  = ce & ~st_r.w_got & ~st_r.bvalid;
  assign s_axi_arready = ce & ~st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = {RD_PAD, st_r.rdata};
  assign s_axi_rresp   = st_r.rresp;

  // Control fields straight from their flops
  assign monitor_gain         = st_r.gain;
  assign cmi_polarity_invert  = st_r.cmi_inv;
  assign cmi_coding_enable    = st_r.cmi_en;
  assign rx_term_sel          = st_r.term_ps[B_RT_HI:B_RT_LO];
  assign tx_term_sel          = st_r.term_ps[B_TT_HI:B_TT_LO];
  assign mclk_prescale        = st_r.term_ps[B_MPS_HI:B_MPS_LO];
  assign ja_clk_select_first  = st_r.ja_first;
  assign ja_clk_select_second = st_r.ja_second;

  // Level output, drops as soon as pending events clear or mask
  assign irq_n = ~((st_r.pend_oc & st_r.mask_oc) |
                   (st_r.pend_cl & st_r.mask_cl) |
                   (st_r.trip & st_r.mask_ja));

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_mon_cmi_wr;
    @(posedge aclk) disable iff (!aresetn)
    $rose(st_r.bvalid) && st_r.aw_idx == IDX_MON_CMI && st_r.wstb |->
      monitor_gain == st_r.wd[B_GAIN_HI:B_GAIN_LO] &&
      cmi_polarity_invert == st_r.wd[B_CMI_INV] &&
      cmi_coding_enable == st_r.wd[B_CMI_EN];
  endproperty
  a_mon_cmi_wr: assert property (p_mon_cmi_wr)
    else $error("line control 3 write not applied");

  property p_term_rd;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && st_r.rd_idx == IDX_TERM_PS |->
      s_axi_rdata[B_RT_HI:B_RT_LO] == rx_term_sel &&
      s_axi_rdata[B_TT_HI:B_TT_LO] == tx_term_sel;
  endproperty
  a_term_rd: assert property (p_term_rd)
    else $error("termination readback mismatch");

  property p_level;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && st_r.rd_idx == IDX_INFO |->
      s_axi_rdata[7:0] == {4'h0, $past(st_r.lv_s2)};
  endproperty
  a_level: assert property (p_level)
    else $error("receive level readback wrong");

  property p_open;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && st_r.rd_idx == IDX_STAT |->
      s_axi_rdata[B_OC] ==
        ($past(st_r.oc_s2) && !$past(tx_mode_6312));
  endproperty
  a_open: assert property (p_open)
    else $error("open circuit flag wrong");

  property p_climit;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && st_r.rd_idx == IDX_STAT &&
      $past(tx_mode_64k || tx_mode_6312 || st_r.cmi_en) |->
      !s_axi_rdata[B_CL];
  endproperty
  a_climit: assert property (p_climit)
    else $error("current limit flag in unsupported mode");

  property p_trip_set;
    @(posedge aclk) disable iff (!aresetn)
    ce && st_r.ja_s2 && mode_t1e1 |=> st_r.trip;
  endproperty
  a_trip_set: assert property (p_trip_set)
    else $error("trip flag not set");

  property p_trip_clr;
    @(posedge aclk) disable iff (!aresetn)
    ce && stat_rd && !(st_r.ja_s2 && mode_t1e1) |=> !st_r.trip;
  endproperty
  a_trip_clr: assert property (p_trip_clr)
    else $error("trip flag not cleared by read");

  property p_edge_irq;
    @(posedge aclk) disable iff (!aresetn)
    ce && oc_now != st_r.oc_q && st_r.mask_oc |=> !irq_n;
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("no interrupt on open circuit edge");

  property p_masked;
    @(posedge aclk) disable iff (!aresetn)
    !st_r.mask_oc && !st_r.mask_cl && !st_r.mask_ja |-> irq_n;
  endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt while all masked");

  property p_ja_rd;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && st_r.rd_idx == IDX_JACK |->
      s_axi_rdata[B_JA1] == ja_clk_select_first &&
      s_axi_rdata[B_JA2] == ja_clk_select_second;
  endproperty
  a_ja_rd: assert property (p_ja_rd)
    else $error("clock select readback mismatch");

endmodule

// File: lcsr_host.sv
// Host processor model: AXI4-Lite master for the register bank
`timescale 1ns/1ps

module lcsr_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [9:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [9:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // One write; aw and w may be taken at different edges
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // No fixed latency assumed; the bench watchdog ends a hang
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // Idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask

  // One read, data taken at the rvalid edge
  task automatic rd(input logic [9:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Idle edge so a following call never re-drives rready in this step
    @(posedge aclk);
  endtask
endmodule

// File: line_interface_ctrl_status_regs_test.sv
// Self-checking bench for the line interface register bank
`timescale 1ns/1ps

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end

module line_interface_ctrl_status_regs_test;
  import lcsr_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic        mode_t1e1 = 1'b1;
  logic        tx_mode_64k = 1'b0;
  logic        tx_mode_6312 = 1'b0;
  logic        tx_open_det = 1'b0;
  logic        tx_climit_det = 1'b0;
  logic        ja_near_limit = 1'b0;
  logic [3:0]  rx_level_in = 4'h0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, monitor_gain, mclk_prescale, rsp;
  logic [2:0]  rx_term_sel, tx_term_sel;
  logic        cmi_polarity_invert, cmi_coding_enable, irq_n;
  logic        ja_clk_select_first, ja_clk_select_second;
  logic [31:0] rdat;
  int          failures = 0;
  int          checks = 0;

  // Clock at 20 MHz
  always #25 aclk = ~aclk;

  lcsr_regs dut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mode_t1e1,
    .tx_mode_64k, .tx_mode_6312, .tx_open_det, .tx_climit_det,
    .ja_near_limit, .rx_level_in, .monitor_gain, .cmi_polarity_invert,
    .cmi_coding_enable, .rx_term_sel, .tx_term_sel, .mclk_prescale,
    .ja_clk_select_first, .ja_clk_select_second, .irq_n);

  lcsr_host host (.aclk, .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .awaddr(s_axi_awaddr), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .bresp(s_axi_bresp), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .araddr(s_axi_araddr), .rvalid(s_axi_rvalid),
    .rready(s_axi_rready), .rdata(s_axi_rdata), .rresp(s_axi_rresp));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wrr(input logic [7:0] i, input logic [7:0] d);
    host.wr(ba(i), d, 4'h1, rsp);
  endtask

  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    host.rd(ba(i), rdat, rsp);
    `CHK(rdat, {24'h00_0000, e})
  endtask

  // Detector inputs pass two flops and an edge stage
  task automatic settle;
    tick(6);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk(IDX_INFO, 8'h00);
    rchk(IDX_STAT, 8'h00);
    rchk(IDX_MASK, 8'h00);
    rchk(IDX_MON_CMI, 8'h00);
    rchk(IDX_TERM_PS, 8'h00);
    `CHK(irq_n, 1'b1)
    $display("test reset done");
  endtask

  task automatic t_mon_cmi;
    // Gain, invert and enable walked independently
    for (int i = 0; i < 16; i++) begin
      wrr(IDX_MON_CMI, {i[3], i[2], 1'b0, i[1:0], 3'b000});
      `CHK(monitor_gain, i[1:0])
      `CHK(cmi_polarity_invert, i[2])
      `CHK(cmi_coding_enable, i[3])
      rchk(IDX_MON_CMI, {i[3], i[2], 1'b0, i[1:0], 3'b000});
    end
    wrr(IDX_MON_CMI, 8'h00);
    $display("test monitor and cmi done");
  endtask

  task automatic t_term_ps;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wrr(IDX_TERM_PS, {c[1:0], ~c, c});
      `CHK(rx_term_sel, c)
      `CHK(tx_term_sel, ~c)
      rchk(IDX_TERM_PS, {c[1:0], ~c, c});
    end
    // T1 table: every prescale code with both first-select settings
    for (int j = 0; j < 8; j++) begin
      wrr(IDX_TERM_PS, {j[1:0], 6'h00});
      wrr(IDX_JACK, {4'h0, j[2], 3'b000});
      `CHK(mclk_prescale, j[1:0])
      `CHK({ja_clk_select_first, ja_clk_select_second}, {j[2], 1'b0})
    end
    // E1 with 12.8 MHz master clock
    wrr(IDX_TERM_PS, 8'h00);
    wrr(IDX_JACK, 8'h80);
    `CHK({ja_clk_select_first, ja_clk_select_second}, 2'b01)
    wrr(IDX_JACK, 8'h00);
    $display("test termination and clocks done");
  endtask

  task automatic t_level;
    logic [3:0] v [4] = '{4'h0, 4'hF, 4'h9, 4'h6};
    foreach (v[k]) begin
      rx_level_in <= v[k];
      settle();
      rchk(IDX_INFO, {4'h0, v[k]});
    end
    $display("test receive level done");
  endtask

  task automatic t_flags;
    wrr(IDX_MASK, 8'h06);
    tx_open_det <= 1'b1;
    settle();
    `CHK(irq_n, 1'b0)
    rchk(IDX_STAT, 8'h02);
    `CHK(irq_n, 1'b1)
    tx_open_det <= 1'b0;
    settle();
    `CHK(irq_n, 1'b0)
    rchk(IDX_STAT, 8'h00);
    // 6312 mode hides both level flags
    tx_mode_6312 <= 1'b1;
    tx_open_det <= 1'b1;
    tx_climit_det <= 1'b1;
    settle();
    rchk(IDX_STAT, 8'h00);
    `CHK(irq_n, 1'b1)
    tx_open_det <= 1'b0;
    settle();
    tx_mode_6312 <= 1'b0;
    settle();
    rchk(IDX_STAT, 8'h04);
    wrr(IDX_MON_CMI, 8'h80);
    settle();
    rchk(IDX_STAT, 8'h00);
    wrr(IDX_MON_CMI, 8'h00);
    tx_mode_64k <= 1'b1;
    settle();
    rchk(IDX_STAT, 8'h00);
    `CHK(irq_n, 1'b1)
    // Masked edge stays hidden until unmasked
    wrr(IDX_MASK, 8'h00);
    tx_mode_64k <= 1'b0;
    settle();
    `CHK(irq_n, 1'b1)
    wrr(IDX_MASK, 8'h04);
    `CHK(irq_n, 1'b0)
    rchk(IDX_STAT, 8'h04);
    tx_climit_det <= 1'b0;
    settle();
    rchk(IDX_STAT, 8'h00);
    $display("test level flags done");
  endtask

  task automatic t_trip;
    wrr(IDX_MASK, 8'h10);
    for (int m = 0; m < 3; m++) begin
      mode_t1e1 <= (m != 2);
      ja_near_limit <= 1'b1;
      tick(2);
      ja_near_limit <= 1'b0;
      settle();
      `CHK(irq_n, (m != 0))
      rchk(IDX_STAT, (m == 2) ? 8'h00 : 8'h10);
      rchk(IDX_STAT, 8'h00);
      `CHK(irq_n, 1'b1)
      wrr(IDX_MASK, 8'h00);
    end
    mode_t1e1 <= 1'b1;
    $display("test trip flag done");
  endtask

  task automatic t_bus;
    host.wr(ba(8'h3F), 8'h55, 4'h1, rsp);
    `CHK(rsp, RESP_SLVERR)
    host.rd(ba(8'h3F), rdat, rsp);
    `CHK(rsp, RESP_SLVERR)
    // Status is read-only; unused bits still read as zero
    wrr(IDX_STAT, 8'h16);
    rchk(IDX_STAT, 8'h00);
    host.wr(ba(IDX_TERM_PS), 8'h12, 4'h0, rsp);
    `CHK(rsp, RESP_OKAY)
    rchk(IDX_TERM_PS, 8'h00);
    ce <= 1'b0;
    tick(1);
    `CHK({s_axi_awready, s_axi_arready}, 2'b00)
    ce <= 1'b1;
    tick(1);
    $display("test bus corners done");
  endtask

  // ****************************************************************
  // Sequence, verdict and watchdog
  // ****************************************************************
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main run
  initial begin
    tick(3);
    aresetn <= 1'b1;
    tick(1);
    t_reset();
    t_mon_cmi();
    t_term_ps();
    t_level();
    t_flags();
    t_trip();
    t_bus();
    summarize();
  end

  // Whole run is well under a thousand cycles; this is ample margin
  initial begin
    tick(20000);
    failures++;
    summarize();
  end
endmodule
